//--- common/eap_pkg.sv
// Package for the extended register access portal: offsets, fields, modes, carriers
// Summary of operation
// [RL1] Indirect access to 32 devices, 65536 registers
// [RL2] Control bits 4:0 select target device
// [RL3] Control bits 15:14 choose portal meaning
// [RL4] Mode 00 pointer; 01 data, no increment
// [RL5] Mode 10 increments after reads and writes
// [RL6] Mode 11 increments after writes only
// [RL7] Mode 00 portal writes/reads stored address
// [RL8] Data modes access register at stored address
// [RL9] Host loads address, sets data mode, writes
// [RL10] Host may stream reads with post increment
// [RL11] Both portal registers reset to zero
// [RL12] Unsupported targets read zero, ignore writes
`default_nettype none

package eap_pkg;

  localparam int          REG_AW        = 5;
  localparam int          DATA_W        = 16;
  localparam int          DEV_W         = 5;
  localparam int          DEV_COUNT     = 32;

  localparam logic [4:0]  REG_CTRL_OFS  = 5'h0d;
  localparam logic [4:0]  REG_DATA_OFS  = 5'h0e;

  localparam int          CTRL_MODE_MSB = 15;
  localparam int          CTRL_MODE_LSB = 14;
  localparam int          CTRL_DEV_MSB  = 4;
  localparam int          CTRL_DEV_LSB  = 0;

  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] PTR_RESET     = 16'h0000;

  localparam int          SYS_CLK_NS    = 20;
  localparam int          EXT_TMO_NS    = 320;
  localparam int          EXT_TMO_CYC   = (EXT_TMO_NS / SYS_CLK_NS) < 1 ? 1
                                          : (EXT_TMO_NS / SYS_CLK_NS);

  typedef enum logic [1:0] {
    EAP_MODE_ADDR    = 2'h0,
    EAP_MODE_DATA    = 2'h1,
    EAP_MODE_INC_RW  = 2'h2,
    EAP_MODE_INC_WR  = 2'h3
  } eap_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [4:0]        addr;
    logic [15:0]       wdata;
  } eap_mgmt_req_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [4:0]        dev;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } eap_ext_req_t;

endpackage : eap_pkg

`default_nettype wire

//--- verilog/eap_ptr_bank.sv
// Per-device stored register address pointers
`default_nettype none

module eap_ptr_bank #(
  parameter int DEVS = 32,
  parameter int DW   = 5,
  parameter int AW   = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic [DW-1:0] sel_dev,
  input  wire logic          load_en,
  input  wire logic [AW-1:0] load_val,
  input  wire logic          inc_en,
  output logic      [AW-1:0] sel_ptr
);

  logic [DEVS-1:0][AW-1:0] ptr_q;

  genvar g;
  generate
    for (g = 0; g < DEVS; g++) begin : g_ptr
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          ptr_q[g] <= AW'(eap_pkg::PTR_RESET);
        end else if (sel_dev == DW'(g)) begin
          if (load_en) begin
            ptr_q[g] <= load_val;                 // [RL7]
          end else if (inc_en) begin
            ptr_q[g] <= ptr_q[g] + {{(AW-1){1'b0}}, 1'b1}; // [RL5] [RL6]
          end
        end
      end
    end
  endgenerate

  assign sel_ptr = ptr_q[sel_dev];

endmodule : eap_ptr_bank

`default_nettype wire

//--- verilog/eap_ext_timer.sv
// Watchdog on an outstanding extended register access
`default_nettype none

module eap_ext_timer #(
  parameter int CYC = 16
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      expired
);

  localparam int          CW    = $clog2(CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYC - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign expired = run && (cnt_reg == LIMIT);

endmodule : eap_ext_timer

`default_nettype wire

//--- verilog/eap_portal.sv
// Control and register/data portal into the extended management register space
`default_nettype none

module eap_portal #(
  parameter logic [31:0] DEV_MASK = 32'hffff_ffff,
  parameter int          TMO_CYC  = eap_pkg::EXT_TMO_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire eap_pkg::eap_mgmt_req_t mgmt_req,
  output logic                       mgmt_ready,
  output logic [15:0]                mgmt_rdata,
  output logic                       mgmt_rvalid,
  output eap_pkg::eap_ext_req_t      ext_req,
  input  wire logic                  ext_ack,
  input  wire logic                  ext_hit,
  input  wire logic [15:0]           ext_rdata,
  output logic [1:0]                 cur_mode,
  output logic [4:0]                 cur_dev
);

  typedef enum logic [1:0] {
    EAP_ST_IDLE = 2'b01,
    EAP_ST_EXT  = 2'b10
  } eap_state_t;

  eap_state_t            state_reg;
  eap_state_t            state_next;
  logic [15:0]           ctrl_reg;
  logic                  ready_reg;
  logic [15:0]           rdata_reg;
  logic                  rvalid_reg;
  eap_pkg::eap_ext_req_t ext_reg;
  logic                  op_wr_reg;
  eap_pkg::eap_mode_t    op_mode_reg;

  eap_pkg::eap_mode_t    mode;
  logic [4:0]            dev;
  logic [15:0]           ptr;
  logic                  take;
  logic                  ctrl_acc;
  logic                  data_acc;
  logic                  data_mode;
  logic                  dev_ok;
  logic                  launch;
  logic                  local_done;
  logic                  finish;
  logic                  expired;
  logic                  ptr_load;
  logic                  ptr_inc;

  // Post increment decision from mode and direction
  function automatic logic inc_after(input eap_pkg::eap_mode_t m, input logic wr);
    inc_after = (m == eap_pkg::EAP_MODE_INC_RW) ||          // [RL5]
                ((m == eap_pkg::EAP_MODE_INC_WR) && wr);    // [RL6]
  endfunction : inc_after

  assign mode      = eap_pkg::eap_mode_t'(ctrl_reg[eap_pkg::CTRL_MODE_MSB:eap_pkg::CTRL_MODE_LSB]);
  assign dev       = ctrl_reg[eap_pkg::CTRL_DEV_MSB:eap_pkg::CTRL_DEV_LSB]; // [RL2]

  // Write wins when both strobes arrive together
  assign take      = ready_reg && (mgmt_req.wr || mgmt_req.rd);
  assign ctrl_acc  = take && (mgmt_req.addr == eap_pkg::REG_CTRL_OFS);
  assign data_acc  = take && (mgmt_req.addr == eap_pkg::REG_DATA_OFS);
  assign data_mode = (mode != eap_pkg::EAP_MODE_ADDR);                      // [RL3]
  assign dev_ok    = DEV_MASK[dev];
  assign launch    = data_acc && data_mode && dev_ok;                       // [RL8]
  assign local_done = data_acc && data_mode && !dev_ok;                     // [RL12]
  assign finish    = (state_reg == EAP_ST_EXT) && (ext_ack || expired);
  assign ptr_load  = data_acc && !data_mode && mgmt_req.wr;                 // [RL7]
  assign ptr_inc   = (local_done && inc_after(mode, mgmt_req.wr)) ||       // [RL12]
                     (finish && inc_after(op_mode_reg, op_wr_reg));        // [RL4]

  eap_ptr_bank #(
    .DEVS (eap_pkg::DEV_COUNT),
    .DW   (eap_pkg::DEV_W),
    .AW   (eap_pkg::DATA_W)
  ) u_ptr_bank (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .sel_dev  (dev),
    .load_en  (ptr_load),
    .load_val (mgmt_req.wdata),
    .inc_en   (ptr_inc),
    .sel_ptr  (ptr)
  );

  eap_ext_timer #(
    .CYC (TMO_CYC)
  ) u_ext_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (state_reg == EAP_ST_EXT),
    .expired (expired)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EAP_ST_IDLE: begin
        if (launch) begin
          state_next = EAP_ST_EXT;
        end
      end
      EAP_ST_EXT: begin
        if (finish) begin
          state_next = EAP_ST_IDLE;
        end
      end
      default: begin
        state_next = EAP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= EAP_ST_IDLE;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == EAP_ST_IDLE);
    end
  end

  // Control register: all sixteen bits stored, reserved ones included
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= eap_pkg::CTRL_RESET;                                     // [RL11]
    end else if (ctrl_acc && mgmt_req.wr) begin
      ctrl_reg <= mgmt_req.wdata;                                          // [RL2] [RL3]
    end
  end

  // Outstanding extended access, held until acknowledged or timed out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_reg     <= '0;
      op_wr_reg   <= 1'b0;
      op_mode_reg <= eap_pkg::EAP_MODE_ADDR;
    end else if (launch) begin
      ext_reg.wr    <= mgmt_req.wr;
      ext_reg.rd    <= !mgmt_req.wr;
      ext_reg.dev   <= dev;
      ext_reg.addr  <= ptr;                                                // [RL1] [RL8]
      ext_reg.wdata <= mgmt_req.wdata;
      op_wr_reg     <= mgmt_req.wr;
      op_mode_reg   <= mode;
    end else if (finish) begin
      ext_reg.wr <= 1'b0;
      ext_reg.rd <= 1'b0;
    end
  end

  // Read answers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      if (ctrl_acc && !mgmt_req.wr) begin
        rdata_reg  <= ctrl_reg;
        rvalid_reg <= 1'b1;
      end else if (data_acc && !data_mode && !mgmt_req.wr) begin
        rdata_reg  <= ptr;                                                 // [RL7]
        rvalid_reg <= 1'b1;
      end else if (local_done && !mgmt_req.wr) begin
        rdata_reg  <= 16'h0000;                                            // [RL12]
        rvalid_reg <= 1'b1;
      end else if (finish && !op_wr_reg) begin
        rdata_reg  <= (ext_ack && ext_hit) ? ext_rdata : 16'h0000;         // [RL8] [RL12]
        rvalid_reg <= 1'b1;
      end
    end
  end

  assign mgmt_ready  = ready_reg;
  assign mgmt_rdata  = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign ext_req     = ext_reg;
  assign cur_mode    = ctrl_reg[eap_pkg::CTRL_MODE_MSB:eap_pkg::CTRL_MODE_LSB];
  assign cur_dev     = ctrl_reg[eap_pkg::CTRL_DEV_MSB:eap_pkg::CTRL_DEV_LSB];

endmodule : eap_portal

`default_nettype wire

//--- verif/eap_portal_assertions.sv
// Checker on the ports of the extended register access portal
`default_nettype none
module eap_portal_assertions #(
  parameter logic [31:0] DEV_MASK = 32'hffff_ffff,
  parameter int          TMO_CYC  = 16
) (
  input wire logic                   sys_clk,
  input wire logic                   srst,
  input wire eap_pkg::eap_mgmt_req_t mgmt_req,
  input wire logic                   mgmt_ready,
  input wire logic [15:0]            mgmt_rdata,
  input wire logic                   mgmt_rvalid,
  input wire eap_pkg::eap_ext_req_t  ext_req,
  input wire logic                   ext_ack,
  input wire logic                   ext_hit,
  input wire logic [15:0]            ext_rdata,
  input wire logic [1:0]             cur_mode,
  input wire logic [4:0]             cur_dev
);
  localparam int TMAX = TMO_CYC + 2;
  logic rq, act;
  assign rq  = mgmt_ready && (mgmt_req.rd || mgmt_req.wr);
  assign act = ext_req.rd || ext_req.wr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_reset_zero: assert property ($fell(srst) |-> !cur_mode && !cur_dev && !mgmt_rvalid)
    else $error("control not zero after reset");
  a_ctrl_write: assert property (rq && mgmt_req.wr && mgmt_req.addr == 5'h0d |=>
    {cur_mode, cur_dev} == {$past(mgmt_req.wdata[15:14]), $past(mgmt_req.wdata[4:0])})
    else $error("control write not stored");
  a_ctrl_read: assert property (rq && !mgmt_req.wr && mgmt_req.addr == 5'h0d |=> mgmt_rvalid
    && mgmt_rdata[15:14] == $past(cur_mode) && mgmt_rdata[4:0] == $past(cur_dev))
    else $error("control read wrong");
  a_addr_local: assert property (rq && mgmt_req.addr == 5'h0e && cur_mode == 2'h0 |=> !act)
    else $error("address mode reached extended side");
  a_ext_device: assert property (act |-> ext_req.dev == cur_dev && cur_mode != 2'h0)
    else $error("extended access to wrong device");
  a_ext_stable: assert property (act && !ext_ack ##1 act |-> $stable(ext_req))
    else $error("extended request changed while waiting");
  a_ack_release: assert property (act && ext_ack |=> !act && mgmt_ready)
    else $error("request not released after ack");
  a_read_data: assert property (ext_req.rd && ext_ack |=> mgmt_rvalid
    && mgmt_rdata == ($past(ext_hit) ? $past(ext_rdata) : 16'h0000))
    else $error("read data not returned");
  a_unsup_zero: assert property (rq && !mgmt_req.wr && mgmt_req.addr == 5'h0e
    && cur_mode != 2'h0 && !DEV_MASK[cur_dev] |=> mgmt_rvalid && mgmt_rdata == 16'h0000)
    else $error("unsupported device read not zero");
  a_wait_bound: assert property (act |-> ##[1:TMAX] !act)
    else $error("extended access never ended");
  cover property (ext_req.rd && ext_ack && ext_hit);
  cover property (ext_req.wr && ext_ack);
  cover property (act ##TMO_CYC act);
endmodule : eap_portal_assertions
bind eap_portal eap_portal_assertions #(.DEV_MASK(DEV_MASK), .TMO_CYC(TMO_CYC)) chk_u (
  .sys_clk(sys_clk), .srst(srst), .mgmt_req(mgmt_req), .mgmt_ready(mgmt_ready),
  .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .ext_req(ext_req), .ext_ack(ext_ack),
  .ext_hit(ext_hit), .ext_rdata(ext_rdata), .cur_mode(cur_mode), .cur_dev(cur_dev));
`default_nettype wire

//--- verif/eap_ext_model.sv
// Behavioural extended register space behind the portal
`default_nettype none
module eap_ext_model (
  input wire eap_pkg::eap_ext_req_t ext_req,
  input wire logic                  sys_clk,
  input wire logic [3:0]            lat,
  input wire logic                  mute,
  output logic                      ext_ack,
  output logic                      ext_hit,
  output logic [15:0]               ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [20:0]];
  logic [20:0] k;
  int          n = 0;
  assign k = {ext_req.dev, ext_req.addr};
  // Outside an answer the data lines toggle so stale values cannot pass
  initial begin
    ext_ack   = 1'b0;
    ext_hit   = 1'b0;
    ext_rdata = 16'h5a5a;
    forever begin
      @(posedge sys_clk);
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      n = ((ext_req.rd || ext_req.wr) && !ext_ack && !mute) ? n + 1 : 0;
      if (n > lat) begin
        n = 0;
        ext_ack <= 1'b1;
        ext_hit <= ext_req.addr < 16'h0100;
        if (ext_req.wr && ext_req.addr < 16'h0100) mem[k] = ext_req.wdata;
        // An address at or above 16'h0100 leaves junk on the data lines; an unwritten one reads zero
        if (ext_req.addr < 16'h0100) ext_rdata <= mem.exists(k) ? mem[k] : 16'h0000;
      end
    end
  end
endmodule : eap_ext_model
`default_nettype wire

//--- verif/eap_portal_tb.sv
// Self-checking bench for the extended register access portal
`default_nettype none
module eap_portal_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk = 1'b0, srst = 1'b1, mute = 1'b0;
  logic                   mgmt_ready, mgmt_rvalid, ext_ack, ext_hit;
  logic [15:0]            mgmt_rdata, ext_rdata, q;
  logic [1:0]             cur_mode;
  logic [4:0]             cur_dev;
  logic [3:0]             lat = 4'h0;
  logic                   s;
  eap_pkg::eap_mgmt_req_t mgmt_req = '0;
  eap_pkg::eap_ext_req_t  ext_req;
  int                     fail_count = 0, samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  eap_portal #(.DEV_MASK(32'h7fff_ffff), .TMO_CYC(4)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .mgmt_req(mgmt_req), .mgmt_ready(mgmt_ready), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .ext_req(ext_req), .ext_ack(ext_ack), .ext_hit(ext_hit),
    .ext_rdata(ext_rdata), .cur_mode(cur_mode), .cur_dev(cur_dev));
  eap_ext_model ext_u (.ext_req(ext_req), .sys_clk(sys_clk), .lat(lat), .mute(mute),
    .ext_ack(ext_ack), .ext_hit(ext_hit), .ext_rdata(ext_rdata));
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One management access; a read waits for its answer
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    s = 1'b0;
    q = 16'hxxxx;
    do begin
      @(posedge sys_clk);
      #1;
    end while (mgmt_ready !== 1'b1);
    @(posedge sys_clk) mgmt_req <= '{w, !w, a, d};
    @(posedge sys_clk) mgmt_req <= '0;
    repeat (12) begin
      #1;
      if (!s && mgmt_rvalid === 1'b1) begin
        s = 1'b1;
        q = mgmt_rdata;
      end
      @(posedge sys_clk);
    end
  endtask : acc
  // Load pointer a, write v and read back in mode m, then inspect the pointer
  task automatic t_mode(input logic [1:0] m, input logic [4:0] dv, input logic [15:0] a,
                        input logic [15:0] v, input logic [15:0] e, input logic [15:0] p);
    acc(1'b1, 5'h0d, {11'h000, dv});
    acc(1'b1, 5'h0e, a);
    acc(1'b1, 5'h0d, {m, 9'h000, dv});
    acc(1'b1, 5'h0e, v);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, e);
    acc(1'b1, 5'h0d, {11'h000, dv});
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, p);
  endtask : t_mode
  task automatic t_local();
    acc(1'b0, 5'h0d, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, 5'h0d, 16'hffff);
    acc(1'b0, 5'h0d, 16'h0000);
    chk(q, 16'hffff);
    acc(1'b0, 5'h05, 16'h0000);
    chk({15'h0000, s}, 16'h0000);
  endtask : t_local
  // Fill two registers and write one out-of-range address with write-only increment, then stream them back
  task automatic t_stream();
    acc(1'b1, 5'h0d, 16'h0004);
    acc(1'b1, 5'h0e, 16'h00fe);
    acc(1'b1, 5'h0d, 16'hc004);
    acc(1'b1, 5'h0e, 16'ha001);
    acc(1'b1, 5'h0e, 16'ha002);
    acc(1'b1, 5'h0e, 16'ha003);
    acc(1'b1, 5'h0d, 16'h0004);
    acc(1'b1, 5'h0e, 16'h00fe);
    acc(1'b1, 5'h0d, 16'h8004);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'ha001);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'ha002);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, 5'h0d, 16'h0004);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'h0101);
  endtask : t_stream
  // Mid-run reset must clear control and the stored pointer of device 4
  task automatic t_reset();
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    acc(1'b0, 5'h0d, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, 5'h0d, 16'h0004);
    acc(1'b0, 5'h0e, 16'h0000);
    chk(q, 16'h0000);
  endtask : t_reset
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_local();
    t_mode(2'h1, 5'h01, 16'h0010, 16'h1234, 16'h1234, 16'h0010);
    t_mode(2'h2, 5'h01, 16'h0020, 16'h5678, 16'h0000, 16'h0022);
    lat <= 4'h2;
    t_mode(2'h3, 5'h03, 16'h0030, 16'h9abc, 16'h0000, 16'h0031);
    t_mode(2'h2, 5'h01, 16'hffff, 16'h1111, 16'h0000, 16'h0001);
    t_mode(2'h1, 5'h1f, 16'h0040, 16'h2222, 16'h0000, 16'h0040);
    t_stream();
    t_reset();
    mute <= 1'b1;
    t_mode(2'h2, 5'h02, 16'h0050, 16'h3333, 16'h0000, 16'h0052);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule : eap_portal_tb
`default_nettype wire
